// >>> din_decoder_consts.svh
// Constant definitions for the servo digital input decoder.
`ifndef DIN_DECODER_CONSTS_SVH
`define DIN_DECODER_CONSTS_SVH
// =====================================
// Widths and field positions
`define DIN_COUNT        10
`define SEL_WIDTH        6
`define SEL_BIT2         2
`define SEL_BIT3         3
`define GROUP_WIDTH      4
`define NODE_WIDTH       8
`define TARGET_WIDTH     10
// =====================================
// Reset values
`define SEL_RESET        6'h00
`define NODE_RESET       8'h00
`define TARGET_RESET     10'h000
`define CNT_RESET        4'h0
// =====================================
// Timing counts at 100 MHz: controller initialisation and braking phases.
`define INIT_TIME_NS     100
`define BRAKE_TIME_NS    100
`define CLK_PERIOD_NS    10
`define INIT_CYCLES      4'((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_ONE          4'h1
`endif

// >>> din_decoder_pkg.sv
// Types shared by the servo digital input decoder.
package din_decoder_pkg;
  // =====================================
  // Drive power-stage sequencing states.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_INIT,
    ST_ON,
    ST_BRAKE,
    ST_FAULT
  } drive_state_t;
endpackage : din_decoder_pkg

// >>> din_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none
module din_sync_edge (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  // The first stage feeds only the second; edges compare stage two and three.
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Registers for the synchroniser chain.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;

  edge_single_a : assert property (@(posedge mclk) disable iff (!nrst)
    rise_o |=> !rise_o) else $error("rise pulse lasted more than one cycle");
endmodule : din_sync_edge
`default_nettype wire

// >>> din_limit_guard.sv
// Direction guard for one limit switch input.
`timescale 1ns/1ps
`default_nettype none
module din_limit_guard (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic passive,
  input  wire logic on_limit_reset,
  input  wire logic drive_off,
  output logic      allow_o,
  output logic      hit_o
);
  logic block_q, block_d;

  // A limit reset while standing on the switch latches a block on that direction.
  // The block is dropped only once the switch turns passive again; drive_off gates hit_o alone.
  always_comb begin
    block_d = block_q;
    if (on_limit_reset && !passive) begin
      block_d = 1'b1;
    end else if (passive) begin
      block_d = 1'b0;
    end
  end

  // Block register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      block_q <= 1'b0;
    end else begin
      block_q <= block_d;
    end
  end

  assign allow_o = passive & ~block_q;
  assign hit_o   = ~passive & ~drive_off;

  guard_block_a : assert property (@(posedge mclk) disable iff (!nrst)
    (!passive) |-> !allow_o) else $error("motion allowed on active limit");
endmodule : din_limit_guard
`default_nettype wire

// >>> din_decoder.sv
// Servo digital input decoder: ten inputs to drive commands.
//
// Contract
// - Ten digital command inputs, zero to nine, are each sampled by the decoder.
// - In positioning mode the six selector inputs form a 6-bit code for one of 64 targets.
// - The selector picks a target within the current position group.
// - In course program mode the selector inputs drive the course program instead.
// - A rising edge of the start input begins a move to the selected target.
// - Motion per direction is allowed only while that limit input is passive.
// - When a limit input loses its passive level the drive brakes at current limit, stage on.
// - A rising enable edge initialises the controller and then turns the power stage on.
// - A falling enable edge brakes to zero speed and then disables the power stage.
// - With an error pending a falling enable edge clears it and returns to ready.
// - On an active limit a falling enable edge resets the limit and blocks that direction.
// - The selector value may be added as an offset to the fieldbus node number.
// - Selector functions work only when both analogue inputs act as digital inputs.
// - With encoder emulation active selector inputs two and three are ignored.
// - With selector two and three used as outputs they are not used as inputs.
`include "din_decoder_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module din_decoder (
  input  wire logic                              mclk,
  input  wire logic                              nrst,
  input  wire logic                              sel_bit0_in,
  input  wire logic                              sel_bit1_in,
  input  wire logic                              sel_bit2_in,
  input  wire logic                              sel_bit3_in,
  input  wire logic                              sel_bit4_in,
  input  wire logic                              sel_bit5_in,
  input  wire logic                              move_start_in,
  input  wire logic                              limit_neg_in,
  input  wire logic                              limit_pos_in,
  input  wire logic                              drive_enable_in,
  input  wire logic                              limit_nc_mode,
  input  wire logic                              course_mode,
  input  wire logic                              analog_as_digital,
  input  wire logic                              encoder_emul_on,
  input  wire logic                              dout12_on,
  input  wire logic                              node_offset_en,
  input  wire logic [`NODE_WIDTH-1:0]            node_base,
  input  wire logic [`GROUP_WIDTH-1:0]           position_group,
  input  wire logic                              error_pending,
  output logic                                   move_start,
  output logic [`TARGET_WIDTH-1:0]               target_index,
  output logic                                   course_valid,
  output logic [`SEL_WIDTH-1:0]                  course_code,
  output logic [`NODE_WIDTH-1:0]                 node_number,
  output logic                                   allow_neg,
  output logic                                   allow_pos,
  output logic                                   limit_brake,
  output logic                                   ctrl_init,
  output logic                                   stage_on,
  output logic                                   motor_brake,
  output logic                                   error_clear,
  output logic                                   ready
);
  import din_decoder_pkg::*;

  // =====================================
  // Input synchronisation
  logic [`DIN_COUNT-1:0] pins;
  logic [`DIN_COUNT-1:0] lvl;
  logic [`DIN_COUNT-1:0] rise;
  logic [`DIN_COUNT-1:0] fall;

  assign pins = {drive_enable_in, limit_pos_in, limit_neg_in, move_start_in,
                 sel_bit5_in, sel_bit4_in, sel_bit3_in, sel_bit2_in,
                 sel_bit1_in, sel_bit0_in};

  // Every input passes its own two-stage chain before any decoding.
  genvar gi;
  generate
    for (gi = 0; gi < `DIN_COUNT; gi = gi + 1) begin : g_sync
      din_sync_edge u_sync (
        .mclk    (mclk),
        .nrst    (nrst),
        .pin_in  (pins[gi]),
        .level_o (lvl[gi]),
        .rise_o  (rise[gi]),
        .fall_o  (fall[gi])
      );
    end
  endgenerate

  // =====================================
  // Selector decoding
  logic                   sel_usable;
  logic                   bits23_lost;
  logic [`SEL_WIDTH-1:0]  sel_code;
  logic                   start_rise;
  logic                   en_rise;
  logic                   en_fall;
  logic                   neg_passive;
  logic                   pos_passive;

  // Shared pins: analogue inputs must act as digital, and bits two and three drop out
  // when they feed the encoder emulation or serve as outputs; they then read as zero.
  always_comb begin
    sel_usable  = analog_as_digital;
    bits23_lost = encoder_emul_on | dout12_on;
    sel_code    = lvl[`SEL_WIDTH-1:0];
    if (bits23_lost) begin
      sel_code[`SEL_BIT2] = 1'b0;
      sel_code[`SEL_BIT3] = 1'b0;
    end
    if (!sel_usable) begin
      sel_code = `SEL_RESET;
    end
  end

  assign start_rise  = rise[`SEL_WIDTH];
  assign en_rise     = rise[`DIN_COUNT-1];
  assign en_fall     = fall[`DIN_COUNT-1];
  // A normally-closed switch is passive at 0 V, a normally-open one at 24 V.
  assign neg_passive = lvl[`SEL_WIDTH+1] ^ limit_nc_mode;
  assign pos_passive = lvl[`SEL_WIDTH+2] ^ limit_nc_mode;

  // =====================================
  // Command outputs
  logic                      move_start_q, move_start_d;
  logic [`TARGET_WIDTH-1:0]  target_q, target_d;
  logic                      course_valid_q, course_valid_d;
  logic [`SEL_WIDTH-1:0]     course_q, course_d;
  logic [`NODE_WIDTH-1:0]    node_q, node_d;

  // Target index joins the group and the in-group code; no adder needed.
  always_comb begin
    move_start_d   = 1'b0;
    target_d       = target_q;
    course_valid_d = course_mode & sel_usable;
    course_d       = course_mode ? sel_code : `SEL_RESET;
    node_d         = node_base;
    if (node_offset_en && sel_usable) begin
      node_d = node_base + {{(`NODE_WIDTH-`SEL_WIDTH){1'b0}}, sel_code};
    end
    if (start_rise && !course_mode && sel_usable) begin
      move_start_d = 1'b1;
      target_d     = {position_group, sel_code};
    end
  end

  // Command registers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      move_start_q   <= 1'b0;
      target_q       <= `TARGET_RESET;
      course_valid_q <= 1'b0;
      course_q       <= `SEL_RESET;
      node_q         <= `NODE_RESET;
    end else begin
      move_start_q   <= move_start_d;
      target_q       <= target_d;
      course_valid_q <= course_valid_d;
      course_q       <= course_d;
      node_q         <= node_d;
    end
  end

  // =====================================
  // Limit switch guards
  logic allow_neg_w, allow_pos_w, hit_neg, hit_pos;
  logic stage_off_w;

  assign stage_off_w = 1'b0;

  din_limit_guard u_neg (
    .mclk           (mclk),
    .nrst           (nrst),
    .passive        (neg_passive),
    .on_limit_reset (en_fall),
    .drive_off      (stage_off_w),
    .allow_o        (allow_neg_w),
    .hit_o          (hit_neg)
  );

  din_limit_guard u_pos (
    .mclk           (mclk),
    .nrst           (nrst),
    .passive        (pos_passive),
    .on_limit_reset (en_fall),
    .drive_off      (stage_off_w),
    .allow_o        (allow_pos_w),
    .hit_o          (hit_pos)
  );

  // =====================================
  // Power stage sequencing
  drive_state_t state_q, state_d;
  logic [3:0]   cnt_q, cnt_d;
  logic         error_clear_d;

  // Initialisation and braking each take a fixed count before the stage changes.
  // An error forces the fault state; only a falling enable edge leaves it.
  always_comb begin
    state_d       = state_q;
    cnt_d         = cnt_q;
    error_clear_d = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (error_pending) begin
          state_d = ST_FAULT;
        end else if (en_rise) begin
          state_d = ST_INIT;
          cnt_d   = `INIT_CYCLES;
        end
      end
      ST_INIT: begin
        if (en_fall) begin
          state_d = ST_OFF;
        end else if (cnt_q == `CNT_ONE) begin
          state_d = ST_ON;
        end else begin
          cnt_d = cnt_q - `CNT_ONE;
        end
      end
      ST_ON: begin
        if (en_fall) begin
          state_d = ST_BRAKE;
          cnt_d   = `INIT_CYCLES;
        end
      end
      ST_BRAKE: begin
        if (cnt_q == `CNT_ONE) begin
          state_d = ST_OFF;
        end else begin
          cnt_d = cnt_q - `CNT_ONE;
        end
      end
      ST_FAULT: begin
        if (en_fall) begin
          state_d       = ST_OFF;
          error_clear_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (error_pending && state_q != ST_FAULT && !error_clear_d) begin
      state_d = ST_FAULT;
    end
  end

  // Sequencer registers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_OFF;
      cnt_q   <= `CNT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // =====================================
  // Registered status outputs
  logic allow_neg_q, allow_pos_q, limit_brake_q, ctrl_init_q, stage_on_q;
  logic motor_brake_q, error_clear_q, ready_q;

  // All drive outputs come from flip-flops, one cycle after the state they show.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      allow_neg_q   <= 1'b0;
      allow_pos_q   <= 1'b0;
      limit_brake_q <= 1'b0;
      ctrl_init_q   <= 1'b0;
      stage_on_q    <= 1'b0;
      motor_brake_q <= 1'b0;
      error_clear_q <= 1'b0;
      ready_q       <= 1'b0;
    end else begin
      allow_neg_q   <= allow_neg_w;
      allow_pos_q   <= allow_pos_w;
      limit_brake_q <= (hit_neg | hit_pos) & (state_q == ST_ON);
      ctrl_init_q   <= state_q == ST_INIT;
      stage_on_q    <= (state_q == ST_ON) | (state_q == ST_BRAKE);
      motor_brake_q <= state_q == ST_BRAKE;
      error_clear_q <= error_clear_d;
      ready_q       <= state_q != ST_FAULT;
    end
  end

  assign move_start   = move_start_q;
  assign target_index = target_q;
  assign course_valid = course_valid_q;
  assign course_code  = course_q;
  assign node_number  = node_q;
  assign allow_neg    = allow_neg_q;
  assign allow_pos    = allow_pos_q;
  assign limit_brake  = limit_brake_q;
  assign ctrl_init    = ctrl_init_q;
  assign stage_on     = stage_on_q;
  assign motor_brake  = motor_brake_q;
  assign error_clear  = error_clear_q;
  assign ready        = ready_q;

  // =====================================
  // Checks
  logic [`GROUP_WIDTH-1:0] position_group_q1;
  logic [`SEL_WIDTH-1:0]   sel_q1;

  // Delayed copies of the target inputs, so the target check sees the values that were taken.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      position_group_q1 <= 4'h0;
      sel_q1            <= `SEL_RESET;
    end else begin
      position_group_q1 <= position_group;
      sel_q1            <= sel_code;
    end
  end

  start_pulse_a : assert property (@(posedge mclk) disable iff (!nrst)
    (start_rise && !course_mode && sel_usable) |=> move_start)
    else $error("start edge did not issue move");
  target_code_a : assert property (@(posedge mclk) disable iff (!nrst)
    move_start |-> target_index == {position_group_q1, sel_q1})
    else $error("target index mismatch");
  init_then_on_a : assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == ST_OFF && en_rise && !error_pending) |=> state_q == ST_INIT ##10 state_q == ST_ON)
    else $error("init did not lead to stage on");
  brake_then_off_a : assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == ST_ON && en_fall && !error_pending) |=> state_q == ST_BRAKE ##10 state_q == ST_OFF)
    else $error("brake did not end in stage off");
  fault_clear_a : assert property (@(posedge mclk) disable iff (!nrst)
    (state_q == ST_FAULT && en_fall) |=> state_q == ST_OFF ##0 error_clear)
    else $error("falling enable did not clear error");
  lost_bits_a : assert property (@(posedge mclk) disable iff (!nrst)
    bits23_lost |-> (sel_code[`SEL_BIT2] == 1'b0 && sel_code[`SEL_BIT3] == 1'b0))
    else $error("selector bits two and three used while unavailable");
  analog_gate_a : assert property (@(posedge mclk) disable iff (!nrst)
    !sel_usable |=> !move_start)
    else $error("move started with selector unusable");
  course_gate_a : assert property (@(posedge mclk) disable iff (!nrst)
    course_mode |=> !move_start)
    else $error("position move in course mode");
  limit_stop_a : assert property (@(posedge mclk) disable iff (!nrst)
    !neg_passive |=> !allow_neg)
    else $error("negative travel allowed on active limit");

  start_cov_c : cover property (@(posedge mclk) disable iff (!nrst) move_start);
  on_cov_c    : cover property (@(posedge mclk) disable iff (!nrst) state_q == ST_ON);
  fault_cov_c : cover property (@(posedge mclk) disable iff (!nrst) error_clear);
  limit_cov_c : cover property (@(posedge mclk) disable iff (!nrst) limit_brake);
endmodule : din_decoder
`default_nettype wire

// >>> din_switch_model.sv
// Machine-side switch and controller model that drives the decoder's input pins.
`timescale 1ns/1ps
`default_nettype none
module din_switch_model (
  input  wire logic       nc_mode,
  input  wire logic [5:0] code,
  input  wire logic       start_req,
  input  wire logic       neg_hit,
  input  wire logic       pos_hit,
  input  wire logic       enable_req,
  output logic      [5:0] sel_pins,
  output logic            start_pin,
  output logic            neg_pin,
  output logic            pos_pin,
  output logic            enable_pin
);
  // ==========================================
  // Pin wiring
  // Selector, start and enable follow the controller's commands directly.
  assign sel_pins   = code;
  assign start_pin  = start_req;
  assign enable_pin = enable_req;
  // A normally-open switch holds the line high while passive, a normally-closed one low.
  // The model inverts the passive level when hit, just as the real wiring would.
  assign neg_pin = neg_hit ^ ~nc_mode;
  assign pos_pin = pos_hit ^ ~nc_mode;
endmodule : din_switch_model
`default_nettype wire

// >>> servo_digital_input_decoder_tb.sv
// Self-checking testbench for the servo digital input decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module servo_digital_input_decoder_tb;
  typedef struct packed {
    logic [5:0] code;
    logic [3:0] grp;
    logic       cm;
    logic       aad;
    logic       emu;
    logic       dout;
    logic       offen;
    logic [7:0] base;
    logic       go;
    logic [9:0] tgt;
    logic [7:0] node;
  } row_t;
  logic mclk = 1'b0, nrst = 1'b0, nc_mode = 1'b0, start_req = 1'b0;
  logic neg_hit = 1'b0, pos_hit = 1'b0, enable_req = 1'b0, error_pending = 1'b0;
  logic cm = 1'b0, aad = 1'b1, emu = 1'b0, dout = 1'b0, offen = 1'b0;
  logic [5:0] code = 6'h00;
  logic [3:0] grp = 4'h0;
  logic [7:0] base = 8'h00;
  logic [5:0] sel_pins;
  logic start_pin, neg_pin, pos_pin, enable_pin;
  logic move_start, course_valid, allow_neg, allow_pos, limit_brake;
  logic ctrl_init, stage_on, motor_brake, error_clear, ready;
  logic [9:0] target_index;
  logic [5:0] course_code;
  logic [7:0] node_number;
  int bad_count = 0, checked = 0, n;
  row_t rows [6];
  // ==========================================
  // Clock and watchdog
  always #5 mclk = ~mclk;
  // The whole sequence needs a few hundred cycles; this leaves wide margin.
  initial begin
    #(20_000 * 10);
    bad_count++;
    finish_test();
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  // ==========================================
  // Device and far-side model
  din_switch_model i_din_switch_model (.nc_mode(nc_mode), .code(code), .start_req(start_req),
    .neg_hit(neg_hit), .pos_hit(pos_hit), .enable_req(enable_req), .sel_pins(sel_pins),
    .start_pin(start_pin), .neg_pin(neg_pin), .pos_pin(pos_pin), .enable_pin(enable_pin));
  din_decoder i_din_decoder (.mclk(mclk), .nrst(nrst), .sel_bit0_in(sel_pins[0]),
    .sel_bit1_in(sel_pins[1]), .sel_bit2_in(sel_pins[2]), .sel_bit3_in(sel_pins[3]),
    .sel_bit4_in(sel_pins[4]), .sel_bit5_in(sel_pins[5]), .move_start_in(start_pin),
    .limit_neg_in(neg_pin), .limit_pos_in(pos_pin), .drive_enable_in(enable_pin),
    .limit_nc_mode(nc_mode), .course_mode(cm), .analog_as_digital(aad),
    .encoder_emul_on(emu), .dout12_on(dout), .node_offset_en(offen), .node_base(base),
    .position_group(grp), .error_pending(error_pending), .move_start(move_start),
    .target_index(target_index), .course_valid(course_valid), .course_code(course_code),
    .node_number(node_number), .allow_neg(allow_neg), .allow_pos(allow_pos),
    .limit_brake(limit_brake), .ctrl_init(ctrl_init), .stage_on(stage_on),
    .motor_brake(motor_brake), .error_clear(error_clear), .ready(ready));
  // ==========================================
  // Main sequence: table of selector cases, then hand-written sequencing cases.
  initial begin
    // Masked rows expect selector bits two and three to read as zero.
    rows[0] = {6'h3f, 4'h0, 5'b01000, 8'h12, 1'b1, 10'h03f, 8'h12};
    rows[1] = {6'h2a, 4'hf, 5'b01001, 8'hc0, 1'b1, 10'h3ea, 8'hea};
    rows[2] = {6'h3f, 4'h5, 5'b01101, 8'h00, 1'b1, 10'h173, 8'h33};
    rows[3] = {6'h0c, 4'h1, 5'b01010, 8'h07, 1'b1, 10'h040, 8'h07};
    rows[4] = {6'h15, 4'h2, 5'b11000, 8'h00, 1'b0, 10'h000, 8'h00};
    rows[5] = {6'h3f, 4'h3, 5'b00000, 8'h55, 1'b0, 10'h000, 8'h55};
    cyc(10);
    `CHECK("ready_in_reset", 1'b0, ready)
    `CHECK("stage_in_reset", 1'b0, stage_on)
    nrst = 1'b1;
    cyc(2);
    `CHECK("ready_after_reset", 1'b1, ready)
    cyc(2);
    foreach (rows[i]) begin
      {code, grp, cm, aad, emu, dout, offen, base} = rows[i][41:19];
      cyc(5);
      `CHECK("node_number", rows[i].node, node_number)
      `CHECK("course_valid", rows[i].cm, course_valid)
      if (rows[i].cm) `CHECK("course_code", rows[i].code, course_code)
      start_req = 1'b1;
      for (n = 0; n < 6 && move_start !== 1'b1; n++) cyc(1);
      `CHECK("move_start", rows[i].go, move_start)
      if (rows[i].go) `CHECK("target_index", rows[i].tgt, target_index)
      cyc(1);
      `CHECK("move_start_once", 1'b0, move_start)
      start_req = 1'b0;
      cyc(3);
    end
    {cm, aad, emu, dout, offen} = 5'b01000;
    // Enable rise: initialise for ten cycles (100 ns at 10 ns), then power stage on.
    enable_req = 1'b1;
    for (n = 0; n < 8 && ctrl_init !== 1'b1; n++) cyc(1);
    for (n = 0; n < 20 && ctrl_init === 1'b1; n++) cyc(1);
    `CHECK("init_length", 10, n)
    `CHECK("stage_after_init", 1'b1, stage_on)
    // Negative limit hit while running: brake at limit, stage stays on.
    neg_hit = 1'b1;
    for (n = 0; n < 8 && allow_neg !== 1'b0; n++) cyc(1);
    `CHECK("allow_neg_hit", 1'b0, allow_neg)
    cyc(1);
    `CHECK("limit_brake", 1'b1, limit_brake)
    `CHECK("stage_at_limit", 1'b1, stage_on)
    `CHECK("allow_pos_free", 1'b1, allow_pos)
    // Enable fall on the limit: brake ten cycles with stage on, then off.
    enable_req = 1'b0;
    for (n = 0; n < 8 && motor_brake !== 1'b1; n++) cyc(1);
    for (n = 0; n < 20 && motor_brake === 1'b1 && stage_on === 1'b1; n++) cyc(1);
    `CHECK("brake_length", 10, n)
    cyc(1);
    `CHECK("stage_after_brake", 1'b0, stage_on)
    enable_req = 1'b1;
    for (n = 0; n < 24 && stage_on !== 1'b1; n++) cyc(1);
    `CHECK("stage_reenabled", 1'b1, stage_on)
    `CHECK("neg_blocked", 1'b0, allow_neg)
    neg_hit = 1'b0;
    cyc(6);
    `CHECK("neg_released", 1'b1, allow_neg)
    // Normally-closed wiring: passive at low level.
    nc_mode = 1'b1;
    cyc(6);
    `CHECK("nc_pos_passive", 1'b1, allow_pos)
    pos_hit = 1'b1;
    cyc(6);
    `CHECK("nc_pos_hit", 1'b0, allow_pos)
    pos_hit = 1'b0;
    nc_mode = 1'b0;
    cyc(6);
    // Pending error: not ready; enable fall clears it with one pulse.
    error_pending = 1'b1;
    cyc(4);
    `CHECK("ready_on_error", 1'b0, ready)
    error_pending = 1'b0;
    enable_req = 1'b0;
    for (n = 0; n < 8 && error_clear !== 1'b1; n++) cyc(1);
    `CHECK("error_clear", 1'b1, error_clear)
    cyc(1);
    `CHECK("error_clear_once", 1'b0, error_clear)
    cyc(2);
    `CHECK("ready_after_clear", 1'b1, ready)
    enable_req = 1'b1;
    for (n = 0; n < 24 && stage_on !== 1'b1; n++) cyc(1);
    `CHECK("stage_after_clear", 1'b1, stage_on)
    // Second reset in mid-run drops the stage at once.
    nrst = 1'b0;
    cyc(1);
    `CHECK("stage_mid_reset", 1'b0, stage_on)
    `CHECK("move_mid_reset", 1'b0, move_start)
    nrst = 1'b1;
    cyc(2);
    `CHECK("ready_rerelease", 1'b1, ready)
    finish_test();
  end
endmodule : servo_digital_input_decoder_tb
`default_nettype wire
